//--- testbench/dsti_ctrl_model.sv
`timescale 1ns/10ps
module dsti_ctrl_model (
   input  wire logic       pclk,
   input  wire logic       on_cylinder,
   output logic            sel_tag,
   output logic            sel_chan_b,
   output logic [3:0]      unit_sel_bits,
   output logic [9:0]      bus_bits,
   output logic            cyl_tag
);
   initial begin
      sel_tag = 1'b0;
      cyl_tag = 1'b0;
      sel_chan_b = 1'b0;
      unit_sel_bits = 4'h0;
      bus_bits = 10'h000;
   end
   // Lines settle a cycle before each tag and are scrambled after it, so stale values cannot help.
   task automatic select(input logic ch, input logic [3:0] code, input logic pr, input logic wide);
      @(posedge pclk);
      sel_chan_b <= ch;
      unit_sel_bits <= wide ? code : ~code;
      bus_bits <= {pr, 5'h00, wide ? ~code : code};
      @(posedge pclk);
      sel_tag <= 1'b1;
      @(posedge pclk);
      sel_tag <= 1'b0;
      @(posedge pclk);
      unit_sel_bits <= ~unit_sel_bits;
      bus_bits <= ~bus_bits;
   endtask
   task automatic seek(input logic [9:0] a);
      int n;
      n = 0;
      @(posedge pclk);
      while (on_cylinder !== 1'b1 && n < 100) begin
         @(posedge pclk);
         n++;
      end
      bus_bits <= a;
      @(posedge pclk);
      cyl_tag <= 1'b1;
      @(posedge pclk);
      cyl_tag <= 1'b0;
      @(posedge pclk);
      bus_bits <= ~a;
   endtask
endmodule

//--- testbench/dsti_top_asserts.sv
`timescale 1ns/10ps
module dsti_top_asserts #(
   parameter int BUS_W = 10
) (
   input wire logic             pclk,
   input wire logic             presetn,
   input wire logic             power_hold_n,
   input wire logic             cable_ok,
   input wire logic             sel_tag,
   input wire logic [BUS_W-1:0] bus_bits,
   input wire logic             seek_done,
   input wire logic             write_gate_in,
   input wire logic             write_gate_out,
   input wire logic             power_on,
   input wire logic             unit_selected,
   input wire logic             reserved,
   input wire logic             on_cylinder,
   input wire logic             seek_start,
   input wire logic [BUS_W-1:0] cyl_addr
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_seek_go;
      seek_start && !on_cylinder ##1 !seek_start;
   endsequence
   sequence s_seek_end;
      !on_cylinder && seek_done;
   endsequence
   chk_gate_inhibit: assert property (write_gate_out |-> write_gate_in && unit_selected && cable_ok && power_on)
      else $error("write gate passed while inhibited");
   chk_open_cable: assert property (!cable_ok |=> !unit_selected && !reserved)
      else $error("selection kept with cable open");
   chk_sel_cause: assert property ($rose(unit_selected) |-> $past(sel_tag) && $past(cable_ok))
      else $error("selected without a select tag");
   chk_seek_addr: assert property (seek_start |-> cyl_addr == $past(bus_bits))
      else $error("cylinder address not taken from bus");
   chk_seek_when: assert property (seek_start |-> $past(on_cylinder) && $past(unit_selected))
      else $error("seek started while not ready");
   chk_seek_pulse: assert property (seek_start |-> s_seek_go)
      else $error("seek start not a single pulse");
   chk_seek_end: assert property (s_seek_end |=> on_cylinder)
      else $error("on cylinder not restored");
   chk_hold_lost: assert property (power_on && power_hold_n |=> !power_on)
      else $error("power kept without hold");
   chk_pwr_rise: assert property ($rose(power_on) |-> $past(power_hold_n) == 1'b0 && $past(power_hold_n, 4) == 1'b0)
      else $error("power came up without hold");
endmodule
bind dsti_top dsti_top_asserts #(.BUS_W(BUS_W)) dsti_top_asserts_inst (.*);

//--- testbench/dsti_top_tb_top.sv
`timescale 1ns/10ps
module dsti_top_tb_top;
   localparam int SEQ = 4;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, seq_pick_n, power_hold_n, cable_ok;
   logic        sel_tag, sel_chan_b, cyl_tag, seek_done, write_gate_in, write_gate_out, power_on, unit_selected;
   logic        reserved, reserve_owner_b, on_cylinder, seek_start, prio_select, ch, pr, wd, dl;
   logic [2:0]  st;
   logic [3:0]  unit_sel_bits, plug, code;
   logic [9:0]  bus_bits, cyl_addr, a;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   int          err_total, total_checks, prio_n, prio_seen, seed, n, i;
   dsti_top #(.SEQ_CYCLES(SEQ)) dsti_top_inst (.*);
   dsti_ctrl_model dsti_ctrl_model_inst (.*);
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   always @(posedge pclk) if (prio_select === 1'b1) prio_seen <= prio_seen + 1;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (pready !== 1'b1) begin
         err_total++;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge pclk);
      @(negedge pclk);
   endtask
   // A reservation blocks the other channel until a priority select takes the drive over.
   // Without dual channel only the selected flag follows the code; reservation is left alone.
   function automatic logic [2:0] expect_sel(input logic [2:0] s, input logic c, input logic p, input logic m,
                                             input logic d);
      if (!d) return {m, s[1:0]};
      if (p) return {2'h3, c};
      if (s[1] && c != s[0]) return s;
      return {m, m, m ? c : s[0]};
   endfunction
   task automatic print_verdict;
      $display("Checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      #2000000;
      err_total++;
      print_verdict;
   end
   initial begin
      {presetn, psel, penable, pwrite, seek_done, write_gate_in, paddr, pwdata} = '0;
      {seq_pick_n, power_hold_n, cable_ok} = 3'h7;
      {err_total, total_checks, prio_n, prio_seen} = '0;
      seed = 32'hAEB8AA41;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 12'h000, 32'h0);
      check(rd, 32'h0);
      apb(1'b0, 12'h004, 32'h0);
      check(rd, 32'h60);
      apb(1'b0, 12'h010, 32'h0);
      check(err, 1'b1);
      check(rd, 32'h0);
      apb(1'b1, 12'h000, 32'hFFFFFFFF);
      apb(1'b0, 12'h000, 32'h0);
      check(rd, 32'hFF);
      $display("Test registers done");
      apb(1'b1, 12'h000, 32'h2);
      seq_pick_n <= 1'b0;
      power_hold_n <= 1'b0;
      tick(10);
      check(power_on, 1'b0);
      plug = 4'($random(seed));
      @(posedge pclk);
      seq_pick_n <= 1'b1;
      apb(1'b1, 12'h000, {24'h0, plug, 4'h7});
      @(posedge pclk);
      seq_pick_n <= 1'b0;
      n = 0;
      while (power_on !== 1'b1 && n < 100) begin
         tick(1);
         n++;
      end
      check(n, SEQ + 1);
      $display("Test power done");
      st = 3'h0;
      for (i = 0; i < 14; i++) begin
         code = (i % 3 == 0) ? plug : 4'($random(seed));
         ch = 1'($random(seed));
         pr = 3'($random(seed)) == 3'h0;
         wd = 1'($random(seed));
         dl = 2'($random(seed)) != 2'h0;
         apb(1'b1, 12'h000, {24'h0, plug, wd, dl, 2'h3});
         dsti_ctrl_model_inst.select(ch, code, pr, wd);
         st = expect_sel(st, ch, pr, code == plug, dl);
         prio_n += pr & dl;
         @(negedge pclk);
         check({unit_selected, reserved, reserved & reserve_owner_b}, {st[2:1], st[1] & st[0]});
      end
      apb(1'b1, 12'h000, {24'h0, plug, 4'h7});
      dsti_ctrl_model_inst.select(1'b0, plug, 1'b1, 1'b0);
      tick(1);
      check(prio_seen, prio_n + 1);
      $display("Test select done");
      for (i = 0; i < 8; i++) begin
         a = (i == 0) ? 10'h3FF : (i == 1) ? 10'h200 : 10'($random(seed));
         dsti_ctrl_model_inst.seek(a);
         @(negedge pclk);
         check({cyl_addr, on_cylinder}, {a, 1'b0});
         apb(1'b0, 12'h008, 32'h0);
         check(rd, {22'h0, a});
         seek_done <= 1'b1;
         @(posedge pclk);
         seek_done <= 1'b0;
         tick(1);
         check(on_cylinder, 1'b1);
      end
      apb(1'b0, 12'h00C, 32'h0);
      check(rd, 32'h8);
      $display("Test seek done");
      write_gate_in <= 1'b1;
      tick(1);
      check(write_gate_out, 1'b1);
      @(posedge pclk);
      cable_ok <= 1'b0;
      tick(2);
      check({write_gate_out, unit_selected, reserved}, 3'h0);
      dsti_ctrl_model_inst.select(1'b0, plug, 1'b1, 1'b0);
      @(negedge pclk);
      check(unit_selected, 1'b0);
      @(posedge pclk);
      cable_ok <= 1'b1;
      power_hold_n <= 1'b1;
      tick(2);
      check(power_on, 1'b0);
      $display("Test inhibit done");
      print_verdict;
   end
endmodule

//--- verilog/dsti_pkg.sv
package dsti_pkg;
   typedef enum logic [1:0] {
      DSTI_PWR_OFF = 2'b00,
      DSTI_PWR_SEQ = 2'b01,
      DSTI_PWR_ON  = 2'b10
   } dsti_pwr_t;
endpackage

//--- verilog/dsti_regs.svh
`ifndef DSTI_REGS_SVH
`define DSTI_REGS_SVH
// How it works
// - Ground on pick line starts power-up only in remote mode with start on.
// - Power-up completes and holds only while the hold line stays grounded.
// - Open cable or lost controller power blocks selection and write gate.
// - Select tag starts selection; code from select bits or bus bits.
// - Dual channel: successful selection reserves drive to issuing channel.
// - Dual channel: select tag with bus bit 9 does priority select.
// - Selected when select code equals logical address plug code, or by a priority select.
// - Cylinder tag latches bus bits as cylinder address and starts seek.
// - Bus bit n maps straight to cylinder address bit n.
// - All ten bus bits form the cylinder address.

`define DSTI_CTRL_OFFSET      12'h000
`define DSTI_STATUS_OFFSET    12'h004
`define DSTI_CYL_OFFSET       12'h008
`define DSTI_SEEKS_OFFSET     12'h00C

`define DSTI_CTRL_REMOTE      0
`define DSTI_CTRL_START       1
`define DSTI_CTRL_DUAL        2
`define DSTI_CTRL_WIDE        3
`define DSTI_CTRL_PLUG_LO     4
`define DSTI_CTRL_PLUG_HI     7
`define DSTI_CTRL_RESET       32'h0000_0000
`define DSTI_CTRL_MASK        32'h0000_00FF

`define DSTI_ST_PWR_LO        0
`define DSTI_ST_PWR_HI        1
`define DSTI_ST_SELECTED      2
`define DSTI_ST_RESERVED      3
`define DSTI_ST_OWNER         4
`define DSTI_ST_ON_CYL        5
`define DSTI_ST_CABLE_OK      6
`define DSTI_ST_PRIO          7

`define DSTI_PRIO_BIT         9
`define DSTI_SEQ_TIME_NS      100000
`define DSTI_CLK_PERIOD_NS    50
`define DSTI_SEQ_CYCLES       ((`DSTI_SEQ_TIME_NS + `DSTI_CLK_PERIOD_NS - 1) / `DSTI_CLK_PERIOD_NS)
`endif

//--- verilog/dsti_rise.sv
`timescale 1ns/10ps
module dsti_rise #(
   parameter bit ACTIVE_LOW = 1'b0
) (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic level,
   output logic      rise
);
   logic active;
   logic prev_reg;

   assign active = ACTIVE_LOW ? ~level : level;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_reg <= 1'b0;
      end else begin
         prev_reg <= active;
      end
   end

   assign rise = active & ~prev_reg;
endmodule

//--- verilog/dsti_top.sv
`timescale 1ns/10ps
`include "dsti_regs.svh"
module dsti_top #(
   parameter int BUS_W      = 10,
   parameter int SEL_W      = 4,
   parameter int SEQ_CYCLES = `DSTI_SEQ_CYCLES
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [11:0]      paddr,
   input  wire logic [31:0]      pwdata,
   output logic      [31:0]      prdata,
   output logic                  pready,
   output logic                  pslverr,
   input  wire logic             seq_pick_n,
   input  wire logic             power_hold_n,
   input  wire logic             cable_ok,
   input  wire logic             sel_tag,
   input  wire logic             sel_chan_b,
   input  wire logic [SEL_W-1:0] unit_sel_bits,
   input  wire logic [BUS_W-1:0] bus_bits,
   input  wire logic             cyl_tag,
   input  wire logic             seek_done,
   input  wire logic             write_gate_in,
   output logic                  write_gate_out,
   output logic                  power_on,
   output logic                  unit_selected,
   output logic                  reserved,
   output logic                  reserve_owner_b,
   output logic                  on_cylinder,
   output logic                  seek_start,
   output logic      [BUS_W-1:0] cyl_addr,
   output logic                  prio_select
);
   localparam int CNT_W = $clog2(SEQ_CYCLES + 1);
   localparam logic [CNT_W-1:0] SEQ_LAST = CNT_W'(SEQ_CYCLES - 1);

   logic [31:0]            ctrl_reg;
   logic [31:0]            ctrl_next;
   dsti_pkg::dsti_pwr_t    pwr_reg;
   dsti_pkg::dsti_pwr_t    pwr_next;
   logic [CNT_W-1:0]       seq_cnt_reg;
   logic                   selected_reg;
   logic                   reserved_reg;
   logic                   owner_reg;
   logic                   on_cyl_reg;
   logic                   seek_reg;
   logic                   prio_reg;
   logic [BUS_W-1:0]       cyl_reg;
   logic [15:0]            seeks_reg;
   logic [31:0]            rdata_reg;
   logic                   err_reg;
   logic                   sel_rise;
   logic                   cyl_rise;
   logic                   remote_mode;
   logic                   start_sw;
   logic                   dual_chan;
   logic                   wide_if;
   logic [SEL_W-1:0]       plug_code;
   logic [SEL_W-1:0]       sel_code;
   logic                   inhibit;
   logic                   code_match;
   logic                   prio_req;
   logic                   chan_allowed;
   logic                   apb_access;
   logic                   addr_ok;
   logic [31:0]            status_word;

   assign remote_mode = ctrl_reg[`DSTI_CTRL_REMOTE];
   assign start_sw    = ctrl_reg[`DSTI_CTRL_START];
   assign dual_chan   = ctrl_reg[`DSTI_CTRL_DUAL];
   assign wide_if     = ctrl_reg[`DSTI_CTRL_WIDE];
   assign plug_code   = ctrl_reg[`DSTI_CTRL_PLUG_HI:`DSTI_CTRL_PLUG_LO];

   dsti_rise #(
      .ACTIVE_LOW (1'b0)
   ) u_sel_rise (
      .pclk    (pclk),
      .presetn (presetn),
      .level   (sel_tag),
      .rise    (sel_rise)
   );

   dsti_rise #(
      .ACTIVE_LOW (1'b0)
   ) u_cyl_rise (
      .pclk    (pclk),
      .presetn (presetn),
      .level   (cyl_tag),
      .rise    (cyl_rise)
   );

   // An open cable also covers a controller that lost power, since its receivers float.
   assign inhibit      = ~cable_ok | (pwr_reg != dsti_pkg::DSTI_PWR_ON);
   assign sel_code     = wide_if ? unit_sel_bits : bus_bits[SEL_W-1:0];
   assign code_match   = (sel_code == plug_code);
   assign prio_req     = dual_chan & bus_bits[`DSTI_PRIO_BIT];
   assign chan_allowed = ~dual_chan | ~reserved_reg | (owner_reg == sel_chan_b);

   always_comb begin
      pwr_next = pwr_reg;
      unique case (pwr_reg)
         dsti_pkg::DSTI_PWR_OFF: begin
            if (!seq_pick_n && remote_mode && start_sw) begin
               pwr_next = dsti_pkg::DSTI_PWR_SEQ;
            end
         end
         dsti_pkg::DSTI_PWR_SEQ: begin
            if (power_hold_n || !remote_mode || !start_sw) begin
               pwr_next = dsti_pkg::DSTI_PWR_OFF;
            end else if (seq_cnt_reg == SEQ_LAST) begin
               pwr_next = dsti_pkg::DSTI_PWR_ON;
            end
         end
         dsti_pkg::DSTI_PWR_ON: begin
            if (power_hold_n || !remote_mode || !start_sw) begin
               pwr_next = dsti_pkg::DSTI_PWR_OFF;
            end
         end
         default: begin
            pwr_next = dsti_pkg::DSTI_PWR_OFF;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwr_reg <= dsti_pkg::DSTI_PWR_OFF;
      end else begin
         pwr_reg <= pwr_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seq_cnt_reg <= '0;
      end else if (pwr_reg == dsti_pkg::DSTI_PWR_SEQ && seq_cnt_reg != SEQ_LAST) begin
         seq_cnt_reg <= seq_cnt_reg + 1'b1;
      end else if (pwr_reg != dsti_pkg::DSTI_PWR_SEQ) begin
         seq_cnt_reg <= '0;
      end
   end

   // A priority select takes the drive regardless of reservation; a plain select from the
   // other channel is refused while the drive is reserved.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         selected_reg <= 1'b0;
         reserved_reg <= 1'b0;
         owner_reg    <= 1'b0;
         prio_reg     <= 1'b0;
      end else if (inhibit) begin
         selected_reg <= 1'b0;
         reserved_reg <= 1'b0;
         prio_reg     <= 1'b0;
      end else begin
         prio_reg <= 1'b0;
         if (sel_rise && prio_req) begin
            selected_reg <= 1'b1;
            reserved_reg <= 1'b1;
            owner_reg    <= sel_chan_b;
            prio_reg     <= 1'b1;
         end else if (sel_rise && chan_allowed) begin
            selected_reg <= code_match;
            if (dual_chan) begin
               reserved_reg <= code_match;
               owner_reg    <= code_match ? sel_chan_b : owner_reg;
            end
         end
      end
   end

   // Seeks need the drive on cylinder; a tag sent mid-seek is dropped rather than queued.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cyl_reg    <= '0;
         seek_reg   <= 1'b0;
         on_cyl_reg <= 1'b1;
         seeks_reg  <= 16'h0000;
      end else begin
         seek_reg <= 1'b0;
         if (cyl_rise && selected_reg && !inhibit && on_cyl_reg) begin
            cyl_reg    <= bus_bits;
            seek_reg   <= 1'b1;
            on_cyl_reg <= 1'b0;
            seeks_reg  <= seeks_reg + 16'h0001;
         end else if (seek_done) begin
            on_cyl_reg <= 1'b1;
         end
      end
   end

   assign write_gate_out  = write_gate_in & selected_reg & ~inhibit;
   assign power_on        = (pwr_reg == dsti_pkg::DSTI_PWR_ON);
   assign unit_selected   = selected_reg;
   assign reserved        = reserved_reg;
   assign reserve_owner_b = owner_reg;
   assign on_cylinder     = on_cyl_reg;
   assign seek_start      = seek_reg;
   assign cyl_addr        = cyl_reg;
   assign prio_select     = prio_reg;

   assign apb_access = psel & penable;
   assign addr_ok    = (paddr == `DSTI_CTRL_OFFSET) || (paddr == `DSTI_STATUS_OFFSET) ||
                       (paddr == `DSTI_CYL_OFFSET) || (paddr == `DSTI_SEEKS_OFFSET);

   always_comb begin
      status_word = 32'h0000_0000;
      status_word[`DSTI_ST_PWR_HI:`DSTI_ST_PWR_LO] = pwr_reg;
      status_word[`DSTI_ST_SELECTED] = selected_reg;
      status_word[`DSTI_ST_RESERVED] = reserved_reg;
      status_word[`DSTI_ST_OWNER]    = owner_reg;
      status_word[`DSTI_ST_ON_CYL]   = on_cyl_reg;
      status_word[`DSTI_ST_CABLE_OK] = cable_ok;
      status_word[`DSTI_ST_PRIO]     = prio_reg;
   end

   always_comb begin
      ctrl_next = ctrl_reg;
      if (apb_access && pwrite && paddr == `DSTI_CTRL_OFFSET) begin
         ctrl_next = pwdata & `DSTI_CTRL_MASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= `DSTI_CTRL_RESET;
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   // Read data is captured in the setup cycle so the access phase completes at once.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_reg <= 32'h0000_0000;
         err_reg   <= 1'b0;
      end else if (psel && !penable) begin
         err_reg <= ~addr_ok;
         unique case (paddr)
            `DSTI_CTRL_OFFSET:   rdata_reg <= ctrl_reg;
            `DSTI_STATUS_OFFSET: rdata_reg <= status_word;
            `DSTI_CYL_OFFSET:    rdata_reg <= {{(32-BUS_W){1'b0}}, cyl_reg};
            `DSTI_SEEKS_OFFSET:  rdata_reg <= {16'h0000, seeks_reg};
            default:             rdata_reg <= 32'h0000_0000;
         endcase
      end
   end

   assign pready  = 1'b1;
   assign pslverr = apb_access & err_reg;
   assign prdata  = rdata_reg;
endmodule
